// ### src/capbuf_readout.sv
// Readout side of the sample capture buffer with APB register access.
// Assumes host pins are asynchronous and sampled on clk; the converter core
// supplies samples on clk.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module capbuf_readout #(
   parameter int DATA_W     = capbuf_pkg::DATA_W,
   parameter int ADDR_W     = capbuf_pkg::ADDR_W,
   parameter int CAL_CYCLES = capbuf_pkg::CAL_CYCLES,
   parameter int SAMPLE_DIV = capbuf_pkg::SAMPLE_DIV
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst_b,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Converter core samples.
   input  wire logic              sample_valid,
   input  wire logic [DATA_W-1:0] sample_data,
   output logic                   sample_tick,
   // Host pins.
   input  wire logic              read_clock_pin,
   input  wire logic              read_strobe_pin,
   input  wire logic              write_strobe_pin,
   input  wire logic              sample_clock_sync_pulse_pos,
   input  wire logic              sample_clock_sync_pulse_neg,
   // Output ports.
   output logic [DATA_W-1:0]      primary_out_bus,
   output logic                   primary_valid_strobe,
   output logic [DATA_W-1:0]      secondary_out_bus,
   output logic                   secondary_valid_strobe,
   output logic                   secondary_out_en,
   output logic                   calibration_active
);

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN  = 2'b10
   } cal_state_t;

   localparam int CAL_W   = $clog2(CAL_CYCLES + 1);
   localparam int PHASE_W = $clog2(SAMPLE_DIV + 1);
   localparam logic [CAL_W-1:0]   CAL_LAST   = CAL_W'(CAL_CYCLES - 1);
   localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SAMPLE_DIV - 1);

   // Synchronised pin levels.
   logic [4:0] pin_level;
   wire        rclk_lvl      = pin_level[0];
   wire        read_lvl      = pin_level[1];
   wire        write_lvl     = pin_level[2];
   wire        sync_pos_lvl  = pin_level[3];
   wire        sync_neg_lvl  = pin_level[4];

   pin_sync #(
      .W (5)
   ) u_pin_sync (
      .clk       (clk),
      .rst_b     (rst_b),
      .pin_in    ({sample_clock_sync_pulse_neg, sample_clock_sync_pulse_pos,
                   write_strobe_pin, read_strobe_pin, read_clock_pin}),
      .level_out (pin_level)
   );

   // Registers.
   logic [15:0]       config_ff;
   logic [15:0]       cap_ctrl_ff;
   logic [31:0]       prdata_ff;
   logic              pslverr_ff;
   cal_state_t        cal_state_ff;
   cal_state_t        nxt_cal_state;
   logic [CAL_W-1:0]  cal_cnt_ff;
   logic [PHASE_W-1:0] phase_ff;
   logic              sync_prev_ff;
   logic              rclk_prev_ff;
   logic [ADDR_W-1:0] wptr_ff;
   logic [ADDR_W-1:0] rptr_ff;
   logic [ADDR_W:0]   fill_ff;
   logic [DATA_W-1:0] primary_ff;
   logic [DATA_W-1:0] secondary_ff;
   logic              valid_strobe_ff;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   function automatic logic [ADDR_W-1:0] ptr_add(input logic [ADDR_W-1:0] p,
                                                 input logic [1:0]        n);
      ptr_add = p + ADDR_W'(n);
   endfunction : ptr_add

   // APB decode.
   wire [5:0] reg_idx     = paddr[7:2];
   wire       hit_config  = (reg_idx == capbuf_pkg::IDX_CONFIG);
   wire       hit_status  = (reg_idx == capbuf_pkg::IDX_STATUS);
   wire       hit_cal     = (reg_idx == capbuf_pkg::IDX_CAL_CMD);
   wire       hit_ctrl    = (reg_idx == capbuf_pkg::IDX_CAP_CTRL);
   wire       mapped      = (paddr[1:0] == 2'b00) &&
                            (hit_config || hit_status || hit_cal || hit_ctrl);
   wire       apb_setup   = psel && !penable;
   wire       apb_access  = psel && penable;
   wire       apb_wr      = apb_access && pwrite && mapped;
   wire       cal_start   = apb_wr && hit_cal && pwdata[capbuf_pkg::CAL_START_BIT];

   // Mode bits steering the data path.
   wire       sync_sel    = config_ff[capbuf_pkg::CFG_SYNC_SEL_BIT];
   wire       dual_port   = cap_ctrl_ff[capbuf_pkg::CTRL_DUAL_PORT_BIT];

   // Sync pulse: positive differential level, rising edge detected.
   wire       sync_diff   = sync_pos_lvl && !sync_neg_lvl;
   wire       sync_rise   = sync_diff && !sync_prev_ff;
   wire       sync_hit    = sync_rise && sync_sel;

   // Readout clock edges seen through the synchroniser.
   wire       rclk_rise   = rclk_lvl && !rclk_prev_ff;
   wire       rclk_fall   = !rclk_lvl && rclk_prev_ff;

   // Reads are withheld while writing, so a host slip cannot corrupt a pair.
   wire       enough      = dual_port ? (fill_ff >= (ADDR_W+1)'(2)) :
                                        (fill_ff != '0);
   wire       read_fire   = rclk_rise && read_lvl && !write_lvl && enough;
   wire       write_fire  = sample_tick && sample_valid && write_lvl;
   wire [1:0] rd_step     = dual_port ? 2'd2 : 2'd1;
   wire [DATA_W-1:0] head_word = mem[rptr_ff];
   wire [DATA_W-1:0] next_word = mem[ptr_add(rptr_ff, 2'd1)];

   wire [31:0] status_word =
      (32'(rptr_ff) << capbuf_pkg::STAT_RPTR_LSB) |
      (32'(fill_ff == '0) << capbuf_pkg::STAT_EMPTY_BIT) |
      (32'(calibration_active) << capbuf_pkg::STAT_CAL_BIT);
   wire [31:0] read_mux =
      hit_config ? {16'h0000, config_ff} :
      hit_ctrl   ? {16'h0000, cap_ctrl_ff} :
      hit_status ? status_word : 32'h0000_0000;

   assign prdata  = prdata_ff;
   assign pready  = apb_access;
   assign pslverr = apb_access && pslverr_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         config_ff   <= capbuf_pkg::CONFIG_RST;
         cap_ctrl_ff <= capbuf_pkg::CAP_CTRL_RST;
         prdata_ff   <= 32'h0000_0000;
         pslverr_ff  <= 1'b0;
      end else begin
         if (apb_setup) begin
            prdata_ff  <= (!pwrite && mapped) ? read_mux : 32'h0000_0000;
            pslverr_ff <= !mapped;
         end
         if (apb_wr && hit_config) begin
            config_ff <= pwdata[15:0];
         end
         if (apb_wr && hit_ctrl) begin
            cap_ctrl_ff <= pwdata[15:0];
         end
      end
   end

   // Calibration sequencer.
   assign calibration_active = (cal_state_ff == CAL_RUN);

   always_comb begin
      nxt_cal_state = cal_state_ff;
      case (cal_state_ff)
         CAL_IDLE: begin
            if (cal_start) begin
               nxt_cal_state = CAL_RUN;
            end
         end
         CAL_RUN: begin
            if (cal_cnt_ff == CAL_LAST) begin
               nxt_cal_state = CAL_IDLE;
            end
         end
         default: begin
            nxt_cal_state = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cal_state_ff <= CAL_IDLE;
         cal_cnt_ff   <= '0;
      end else begin
         cal_state_ff <= nxt_cal_state;
         cal_cnt_ff   <= (cal_state_ff == CAL_RUN) ? cal_cnt_ff + 1'b1 : '0;
      end
   end

   // Internal sample clock phase, realigned by the sync pulse.
   assign sample_tick = (phase_ff == PHASE_LAST);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         phase_ff     <= '0;
         sync_prev_ff <= 1'b0;
      end else begin
         sync_prev_ff <= sync_diff;
         if (sync_hit) begin
            phase_ff <= '0;
         end else if (sample_tick) begin
            phase_ff <= '0;
         end else begin
            phase_ff <= phase_ff + 1'b1;
         end
      end
   end

   // Capture memory write side; no reset on the array itself.
   always_ff @(posedge clk) begin
      if (write_fire) begin
         mem[wptr_ff] <= sample_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         fill_ff <= '0;
      end else begin
         if (write_fire) begin
            wptr_ff <= ptr_add(wptr_ff, 2'd1);
         end
         if (read_fire) begin
            rptr_ff <= ptr_add(rptr_ff, rd_step);
         end
         fill_ff <= fill_ff + (ADDR_W+1)'(write_fire)
                    - (read_fire ? (ADDR_W+1)'(rd_step) : '0);
      end
   end

   // Output ports: data changes only on a read; the primary strobe mirrors the read clock, the secondary one only in dual port mode.
   assign primary_out_bus        = primary_ff;
   assign secondary_out_bus      = secondary_ff;
   assign primary_valid_strobe   = valid_strobe_ff;
   assign secondary_valid_strobe = valid_strobe_ff && dual_port;
   assign secondary_out_en       = dual_port;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         primary_ff      <= '0;
         secondary_ff    <= '0;
         rclk_prev_ff    <= 1'b0;
         valid_strobe_ff <= 1'b0;
      end else begin
         rclk_prev_ff <= rclk_lvl;
         if (rclk_rise) begin
            valid_strobe_ff <= 1'b1;
         end else if (rclk_fall) begin
            valid_strobe_ff <= 1'b0;
         end
         if (read_fire && dual_port) begin
            secondary_ff <= head_word;
            primary_ff   <= next_word;
         end else if (read_fire) begin
            primary_ff   <= head_word;
         end
      end
   end

   // Checks.
   sequence s_read_dual;
      read_fire && dual_port;
   endsequence

   sequence s_read_single;
      read_fire && !dual_port;
   endsequence

   property p_sync_realign;
      @(posedge clk) disable iff (!rst_b)
      (sync_rise && sync_sel) |=> (phase_ff == '0) ##1 (phase_ff == PHASE_W'(1));
   endproperty
   a_sync_realign : assert property (p_sync_realign)
      else $error("sync pulse did not realign the sample phase");

   property p_sync_ignored;
      @(posedge clk) disable iff (!rst_b)
      (sync_rise && !sync_sel && !sample_tick) |=> (phase_ff == $past(phase_ff) + 1'b1);
   endproperty
   a_sync_ignored : assert property (p_sync_ignored)
      else $error("sync pulse acted while not selected");

   property p_cal_span;
      @(posedge clk) disable iff (!rst_b)
      (cal_start && !calibration_active) |=> calibration_active [*8];
   endproperty
   a_cal_span : assert property (p_cal_span)
      else $error("calibration output dropped early");

   property p_cal_end;
      @(posedge clk) disable iff (!rst_b)
      (calibration_active && cal_cnt_ff == CAL_LAST) |=> !calibration_active;
   endproperty
   a_cal_end : assert property (p_cal_end)
      else $error("calibration output stayed high after the run");

   property p_dual_pair;
      @(posedge clk) disable iff (!rst_b)
      s_read_dual |=> (secondary_ff == $past(head_word)) && (primary_ff == $past(next_word))
                      && (rptr_ff == ptr_add($past(rptr_ff), 2'd2));
   endproperty
   a_dual_pair : assert property (p_dual_pair)
      else $error("dual port pair order or pointer step wrong");

   property p_single_word;
      @(posedge clk) disable iff (!rst_b)
      s_read_single |=> (primary_ff == $past(head_word))
                        && (rptr_ff == ptr_add($past(rptr_ff), 2'd1));
   endproperty
   a_single_word : assert property (p_single_word)
      else $error("single port read did not deliver the next sample");

   property p_secondary_off;
      @(posedge clk) disable iff (!rst_b)
      !cap_ctrl_ff[capbuf_pkg::CTRL_DUAL_PORT_BIT] |-> !secondary_out_en && !secondary_valid_strobe;
   endproperty
   a_secondary_off : assert property (p_secondary_off)
      else $error("secondary port driven in single port mode");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      !read_lvl |=> $stable(primary_ff);
   endproperty
   a_hold : assert property (p_hold)
      else $error("primary data changed without a read");

   property p_strobe_align;
      @(posedge clk) disable iff (!rst_b)
      read_fire |=> primary_valid_strobe && $rose(primary_valid_strobe);
   endproperty
   a_strobe_align : assert property (p_strobe_align)
      else $error("valid strobe not aligned with data change");

   property p_no_read_in_write;
      @(posedge clk) disable iff (!rst_b)
      write_lvl |-> !read_fire;
   endproperty
   a_no_read_in_write : assert property (p_no_read_in_write)
      else $error("read taken while the write strobe was high");

   property p_secondary_step;
      @(posedge clk) disable iff (!rst_b)
      s_read_dual |=> (fill_ff == $past(fill_ff) - (ADDR_W+1)'(2) + (ADDR_W+1)'($past(write_fire)));
   endproperty
   a_secondary_step : assert property (p_secondary_step)
      else $error("dual port read did not consume two samples");

   property p_secondary_data;
      @(posedge clk) disable iff (!rst_b)
      (dual_port && !read_fire) |=> $stable(secondary_ff);
   endproperty
   a_secondary_data : assert property (p_secondary_data)
      else $error("secondary data changed without a read");

   property p_primary_later;
      @(posedge clk) disable iff (!rst_b)
      s_read_dual |=> (primary_ff == mem[ptr_add($past(rptr_ff), 2'd1)]);
   endproperty
   a_primary_later : assert property (p_primary_later)
      else $error("primary port did not carry the later sample");

endmodule : capbuf_readout
`default_nettype wire

// ### src/capbuf_pkg.sv
// Constants shared by the capture buffer readout block and its testbench.
// Assumes one 20 MHz system clock; register indices are word indices on APB.
package capbuf_pkg;

   // Register indices; the APB byte address is four times the index.
   localparam logic [5:0]  IDX_CONFIG      = 6'h01;
   localparam logic [5:0]  IDX_STATUS      = 6'h02;
   localparam logic [5:0]  IDX_CAL_CMD     = 6'h03;
   localparam logic [5:0]  IDX_CAP_CTRL    = 6'h0F;

   // Field positions.
   localparam int          CFG_SYNC_SEL_BIT   = 14;
   localparam int          CTRL_DUAL_PORT_BIT = 12;
   localparam int          CAL_START_BIT      = 0;
   localparam int          STAT_CAL_BIT       = 0;
   localparam int          STAT_EMPTY_BIT     = 1;
   localparam int          STAT_RPTR_LSB      = 16;

   // Reset values.
   localparam logic [15:0] CONFIG_RST     = 16'h0000;
   localparam logic [15:0] CAP_CTRL_RST   = 16'h0000;

   // Timing.
   localparam int          CLK_PERIOD_NS  = 50;
   localparam int          CAL_TIME_US    = 100;
   localparam int          CAL_CYCLES     = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int          SAMPLE_DIV     = 4;

   // Buffer geometry.
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 12;

endpackage : capbuf_pkg

// ### src/pin_sync.sv
// Three-stage pin synchroniser with an agreement filter on the last two stages.
// Assumes asynchronous pin levels and a single system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Pins in, filtered levels out.
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);

   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;
   logic [W-1:0] stage3_ff;
   logic [W-1:0] level_ff;
   logic [W-1:0] nxt_level;
   wire  [W-1:0] agree = ~(stage2_ff ^ stage3_ff);

   // A bit only moves once the second and third stages show the same value.
   assign nxt_level = (agree & stage2_ff) | (~agree & level_ff);
   assign level_out = level_ff;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
         stage3_ff <= '0;
         level_ff  <= '0;
      end else begin
         stage1_ff <= pin_in;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         level_ff  <= nxt_level;
      end
   end

   property p_filter_agree;
      @(posedge clk) disable iff (!rst_b)
      (stage2_ff == stage3_ff) |=> (level_ff == $past(stage2_ff));
   endproperty
   a_filter_agree : assert property (p_filter_agree)
      else $error("filtered level did not follow agreeing stages");

endmodule : pin_sync
`default_nettype wire

// ### verif/host_reader.sv
// Host-side model driving the readout pins of the capture buffer.
// Assumes clk is the system clock; every pin changes just after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_reader #(
   parameter int HALF = 8
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Requests from the bench.
   input  wire logic read_req,
   input  wire logic write_req,
   input  wire logic sync_req,
   // Pins towards the device.
   output logic      read_clock_pin,
   output logic      read_strobe_pin,
   output logic      write_strobe_pin,
   output logic      sync_pos,
   output logic      sync_neg
);
   int cnt_ff;

   initial begin
      cnt_ff = 0;
      read_clock_pin = 1'b0;
      read_strobe_pin = 1'b0;
      write_strobe_pin = 1'b0;
      sync_pos = 1'b0;
      sync_neg = 1'b1;
   end

   // The read clock runs free, as a real host clock would, even through reset.
   always @(posedge clk) begin
      cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
      if (cnt_ff == HALF - 1) read_clock_pin <= ~read_clock_pin;
      write_strobe_pin <= rst_b & write_req;
      read_strobe_pin <= rst_b & read_req & ~write_req & ~write_strobe_pin;
      sync_pos <= rst_b & sync_req;
      sync_neg <= ~(rst_b & sync_req);
   end
endmodule : host_reader
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the capture buffer readout block.
// Assumes host_reader drives the host pins; the bench plays APB master and core.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int         CAL_N  = 10;
   localparam logic [7:0] A_CFG  = {capbuf_pkg::IDX_CONFIG, 2'b00};
   localparam logic [7:0] A_STAT = {capbuf_pkg::IDX_STATUS, 2'b00};
   localparam logic [7:0] A_CAL  = {capbuf_pkg::IDX_CAL_CMD, 2'b00};
   localparam logic [7:0] A_CTRL = {capbuf_pkg::IDX_CAP_CTRL, 2'b00};

   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, sample_data, pri, sec, last;
   logic [31:0] pwdata, prdata, q;
   logic        sample_valid, sample_tick, read_req, write_req, sync_req, e;
   logic        rclk, rstb_pin, wstb_pin, s_pos, s_neg, pri_vld, sec_vld, sec_en, cal;
   logic [11:0] p;
   logic [7:0]  pq[$], sq[$];
   int          n_mismatch, total_checks, odd_ff, last_ff, cyc_ff, n;

   capbuf_readout #(.CAL_CYCLES(CAL_N)) dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sample_data(sample_data), .sample_tick(sample_tick),
      .read_clock_pin(rclk), .read_strobe_pin(rstb_pin), .write_strobe_pin(wstb_pin),
      .sample_clock_sync_pulse_pos(s_pos), .sample_clock_sync_pulse_neg(s_neg),
      .primary_out_bus(pri), .primary_valid_strobe(pri_vld), .secondary_out_bus(sec),
      .secondary_valid_strobe(sec_vld), .secondary_out_en(sec_en),
      .calibration_active(cal));

   host_reader host (
      .clk(clk), .rst_b(rst_b), .read_req(read_req), .write_req(write_req),
      .sync_req(sync_req), .read_clock_pin(rclk), .read_strobe_pin(rstb_pin),
      .write_strobe_pin(wstb_pin), .sync_pos(s_pos), .sync_neg(s_neg));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // The core hands out a rising count, so stored samples are consecutive values.
   always @(posedge clk) begin
      cyc_ff <= cyc_ff + 1;
      if (sample_tick === 1'b1 && sample_valid) sample_data <= sample_data + 8'h01;
      if (sample_tick === 1'b1) begin
         last_ff <= cyc_ff;
         if (last_ff != 0 && cyc_ff - last_ff != capbuf_pkg::SAMPLE_DIV) odd_ff <= odd_ff + 1;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only pready ends this wait; the slave decides how long it takes.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rq;
      logic        re;
      apb(1'b1, a, d, rq, re);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, q, e);
   endtask : rd

   // Each read clock rise inside the strobe window yields one read.
   task automatic do_reads(input int k, input logic dual);
      @(negedge rclk);
      @(posedge clk);
      read_req <= 1'b1;
      for (int i = 0; i < k; i++) begin
         @(posedge rclk);
         repeat (7) @(posedge clk);
         #1;
         check({31'h0, pri_vld}, 32'h1);
         check({31'h0, sec_vld}, {31'h0, dual});
         pq.push_back(pri);
         sq.push_back(sec);
      end
      @(negedge rclk);
      @(posedge clk);
      read_req <= 1'b0;
   endtask : do_reads

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sample_valid = 1'b0;
      sample_data = 8'h00;
      read_req = 1'b0;
      write_req = 1'b0;
      sync_req = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      odd_ff = 0;
      last_ff = 0;
      cyc_ff = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(A_CFG);
      check(q, {16'h0, capbuf_pkg::CONFIG_RST});
      rd(A_CTRL);
      check(q, {16'h0, capbuf_pkg::CAP_CTRL_RST});
      apb(1'b0, 8'h10, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      wr(A_CAL, 32'h1);
      n = 0;
      // The first sample falls just after the edge that starts the calibration.
      repeat (CAL_N + 8) begin
         #1;
         if (cal === 1'b1) n++;
         @(posedge clk);
      end
      check(32'(n), 32'(CAL_N));
      wr(A_CAL, 32'h1);
      rd(A_STAT);
      check({31'h0, q[capbuf_pkg::STAT_CAL_BIT]}, 32'h1);
      repeat (20) @(posedge clk);
      // Pulses at all four tick offsets: a realign moves the phase for three of them.
      for (int s = 0; s < 2; s++) begin
         wr(A_CFG, 32'(s) << capbuf_pkg::CFG_SYNC_SEL_BIT);
         n = odd_ff;
         for (int o = 0; o < 4; o++) begin
            do @(posedge clk); while (sample_tick !== 1'b1);
            repeat (o) @(posedge clk);
            sync_req <= 1'b1;
            repeat (3) @(posedge clk);
            sync_req <= 1'b0;
            repeat (20) @(posedge clk);
         end
         check(32'(odd_ff - n), 32'(s * 3));
      end
      sample_valid <= 1'b1;
      write_req <= 1'b1;
      repeat (160) @(posedge clk);
      sample_valid <= 1'b0;
      write_req <= 1'b0;
      repeat (10) @(posedge clk);
      rd(A_STAT);
      check({31'h0, q[capbuf_pkg::STAT_EMPTY_BIT]}, 32'h0);
      p = q[27:16];
      do_reads(6, 1'b0);
      for (int i = 0; i < 6; i++) check({24'h0, pq[i]}, {24'h0, 8'(pq[0] + i)});
      rd(A_STAT);
      check({20'h0, q[27:16]}, {20'h0, 12'(p + 6)});
      last = pri;
      repeat (48) @(posedge clk);
      #1;
      check({24'h0, pri}, {24'h0, last});
      check({31'h0, sec_en}, 32'h0);
      wr(A_CTRL, 32'h1 << capbuf_pkg::CTRL_DUAL_PORT_BIT);
      rd(A_CTRL);
      check(q, 32'h1 << capbuf_pkg::CTRL_DUAL_PORT_BIT);
      check({31'h0, sec_en}, 32'h1);
      pq.delete();
      sq.delete();
      do_reads(6, 1'b1);
      for (int i = 0; i < 6; i++) begin
         check({24'h0, sq[i]}, {24'h0, 8'(last + 1 + 2 * i)});
         check({24'h0, pq[i]}, {24'h0, 8'(last + 2 + 2 * i)});
      end
      rd(A_STAT);
      check({20'h0, q[27:16]}, {20'h0, 12'(p + 18)});
      complete_run();
   end
endmodule : testbench
`default_nettype wire
